// file: hw/upsi_top.sv
// usb power state indicator with axi4-lite register slave
// Functional notes
// - low power class: assert only when suspended
// - high power class: suspended or unconfigured asserts
// - deassert when full current is allowed
// - default active low, otp selects high
// - self powered: drop pull-up without supply
// - supply sense ignored unless enabled, self powered
// - full-speed usb 2.0 function
// - ep0, one config, two interfaces, three endpoints
// - default vendor code, otp override
// - default product code, otp override
`timescale 1ns/100ps
`default_nettype none
module upsi_top
    import upsi_pkg::*;
#(
    parameter logic [15:0] DEFAULT_VID = 16'h1234, // arbitrary value
    parameter logic [15:0] DEFAULT_PID = 16'h5679  // arbitrary value
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic bus_supply_sense_in,
    output logic power_permission_out,
    output logic usb_data_positive_pullup
);
    // control register fields
    logic suspended; // usb function suspended
    logic configured; // host has configured device
    logic [7:0] maxPower; // requested max power, 2 ma units
    // otp option register
    logic [4:0] otpOpts;
    // stored identity codes
    logic [15:0] storedVid;
    logic [15:0] storedPid;
    // block outputs
    logic lowPowerActive;
    logic [15:0] vendorId;
    logic [15:0] productId;
    // write channel holding
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    // current word at the write address, and that word after the write
    logic [31:0] curWord;
    logic [31:0] newWord;
    // read holding
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // byte-lane merge of a write into a word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // present contents of the addressed writable register
    always_comb begin
        curWord = 32'h0000_0000;
        case (awAddr[7:2])
            UPSI_CTRL_OFS[7:2]: begin
                curWord = {16'h0000, maxPower, 6'h00, configured, suspended};
            end
            UPSI_OTP_OFS[7:2]: begin
                curWord = {27'h0, otpOpts};
            end
            UPSI_IDS_OFS[7:2]: begin
                curWord = {storedPid, storedVid};
            end
            default: begin
                curWord = 32'h0000_0000;
            end
        endcase
        newWord = merge(curWord, wData, wStrb);
    end

    // address and data accepted independently, one write at a time
    assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
    assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    // capture write address
    always_ff @(posedge mclk) begin
        if (rst) begin
            awHeld <= 1'b0;
            awAddr <= 8'h00;
        end else if (s_axi_awvalid & s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
        end else if (awHeld & wHeld) begin
            awHeld <= 1'b0;
        end
    end

    // capture write data
    always_ff @(posedge mclk) begin
        if (rst) begin
            wHeld <= 1'b0;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
        end else if (s_axi_wvalid & s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end else if (awHeld & wHeld) begin
            wHeld <= 1'b0;
        end
    end

    // register update and write response
    always_ff @(posedge mclk) begin
        if (rst) begin
            suspended <= 1'b0;
            configured <= 1'b0;
            maxPower <= UPSI_MAXP_RST;
            otpOpts <= 5'h00;
            storedVid <= UPSI_ID_RST;
            storedPid <= UPSI_ID_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= UPSI_RESP_OKAY;
        end else begin
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (awHeld & wHeld) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= UPSI_RESP_OKAY;
                case (awAddr[7:2])
                    UPSI_CTRL_OFS[7:2]: begin
                        {maxPower, configured, suspended} <=
                            {newWord[15:8], newWord[1:0]};
                    end
                    UPSI_OTP_OFS[7:2]: begin
                        otpOpts <= newWord[4:0];
                    end
                    UPSI_IDS_OFS[7:2]: begin
                        {storedPid, storedVid} <= newWord;
                    end
                    default: begin
                        s_axi_bresp <= UPSI_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // read decode
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = UPSI_RESP_OKAY;
        case (s_axi_araddr[7:2])
            UPSI_CTRL_OFS[7:2]: begin
                next_rdata = {16'h0000, maxPower, 6'h00, configured,
                              suspended};
            end
            UPSI_OTP_OFS[7:2]: begin
                next_rdata = {27'h0, otpOpts};
            end
            UPSI_IDS_OFS[7:2]: begin
                next_rdata = {productId, vendorId};
            end
            UPSI_STATUS_OFS[7:2]: begin
                next_rdata = {29'h0, usb_data_positive_pullup,
                              power_permission_out, lowPowerActive};
            end
            UPSI_EPINFO_OFS[7:2]: begin
                next_rdata = UPSI_EPINFO;
            end
            default: begin
                next_rresp = UPSI_RESP_SLVERR;
            end
        endcase
    end

    // read response register
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= UPSI_RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // power permission and pull-up decision
    upsi_power_logic u_power (
        .mclk(mclk),
        .rst(rst),
        .suspended(suspended),
        .configured(configured),
        .maxPower(maxPower),
        .polarityHigh(otpOpts[UPSI_OTP_POLHI_BIT]),
        .senseEnable(otpOpts[UPSI_OTP_SENSE_BIT]),
        .selfPowered(otpOpts[UPSI_OTP_SELFP_BIT]),
        .bus_supply_sense_in(bus_supply_sense_in),
        .power_permission_out(power_permission_out),
        .pullupEnable(usb_data_positive_pullup),
        .lowPowerActive(lowPowerActive)
    );

    // identity code choice
    upsi_id_select #(
        .DEFAULT_VID(DEFAULT_VID),
        .DEFAULT_PID(DEFAULT_PID)
    ) u_ids (
        .mclk(mclk),
        .rst(rst),
        .vidWritten(otpOpts[UPSI_OTP_VIDW_BIT]),
        .pidWritten(otpOpts[UPSI_OTP_PIDW_BIT]),
        .storedVid(storedVid),
        .storedPid(storedPid),
        .vendorId(vendorId),
        .productId(productId)
    );
endmodule
`default_nettype wire

// file: inc/upsi_pkg.sv
// shared constants for the usb power state indicator block
package upsi_pkg;
    // register byte offsets
    localparam logic [7:0] UPSI_CTRL_OFS = 8'h00;
    localparam logic [7:0] UPSI_OTP_OFS = 8'h04;
    localparam logic [7:0] UPSI_IDS_OFS = 8'h08;
    localparam logic [7:0] UPSI_STATUS_OFS = 8'h0c;
    localparam logic [7:0] UPSI_EPINFO_OFS = 8'h10;
    // ctrl fields
    localparam int UPSI_CTRL_SUSP_BIT = 0;
    localparam int UPSI_CTRL_CONF_BIT = 1;
    localparam int UPSI_CTRL_MAXP_LSB = 8;
    // otp fields
    localparam int UPSI_OTP_POLHI_BIT = 0;
    localparam int UPSI_OTP_SENSE_BIT = 1;
    localparam int UPSI_OTP_SELFP_BIT = 2;
    localparam int UPSI_OTP_VIDW_BIT = 3;
    localparam int UPSI_OTP_PIDW_BIT = 4;
    // reset values and the one unit load threshold
    localparam logic [7:0] UPSI_MAXP_RST = 8'h32;
    localparam logic [7:0] UPSI_UNIT_LOAD = 8'h32;
    localparam logic [15:0] UPSI_ID_RST = 16'h0000;
    // endpoint summary: fs usb 2.0, 1 config, 2 ifaces, ep0/int/bin/bout
    localparam logic [31:0] UPSI_EPINFO = 32'h0200_1214;
    // axi responses
    localparam logic [1:0] UPSI_RESP_OKAY = 2'b00;
    localparam logic [1:0] UPSI_RESP_SLVERR = 2'b10;
endpackage

// file: hw/upsi_power_logic.sv
// power permission level and data line pull-up decision
`timescale 1ns/100ps
`default_nettype none
module upsi_power_logic
    import upsi_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // usb function state
    input wire logic suspended,
    input wire logic configured,
    input wire logic [7:0] maxPower,
    // options
    input wire logic polarityHigh,
    input wire logic senseEnable,
    input wire logic selfPowered,
    input wire logic bus_supply_sense_in,
    // results
    output logic power_permission_out,
    output logic pullupEnable,
    output logic lowPowerActive
);
    // high power class when request exceeds one unit load
    logic highPower;
    logic next_power_permission_out;
    assign highPower = maxPower > UPSI_UNIT_LOAD;

    // asserting condition per power class
    always_comb begin
        if (highPower) begin
            next_power_permission_out = suspended | ~configured;
        end else begin
            next_power_permission_out = suspended;
        end
    end

    // one-clock registered level, polarity applied
    always_ff @(posedge mclk) begin
        if (rst) begin
            lowPowerActive <= 1'b1;
            power_permission_out <= 1'b0;
        end else begin
            lowPowerActive <= next_power_permission_out;
            power_permission_out <= polarityHigh ? next_power_permission_out
                                                 : ~next_power_permission_out;
        end
    end

    // pull-up gated by supply sense only when self powered and enabled
    always_ff @(posedge mclk) begin
        if (rst) begin
            pullupEnable <= 1'b0;
        end else begin
            pullupEnable <= ~(selfPowered & senseEnable
                              & ~bus_supply_sense_in);
        end
    end
endmodule
`default_nettype wire

// file: hw/upsi_id_select.sv
// chooses reported vendor and product codes
`timescale 1ns/100ps
`default_nettype none
module upsi_id_select
    import upsi_pkg::*;
#(
    parameter logic [15:0] DEFAULT_VID = 16'h1234, // arbitrary value
    parameter logic [15:0] DEFAULT_PID = 16'h5679  // arbitrary value
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // stored codes
    input wire logic vidWritten,
    input wire logic pidWritten,
    input wire logic [15:0] storedVid,
    input wire logic [15:0] storedPid,
    // reported codes
    output logic [15:0] vendorId,
    output logic [15:0] productId
);
    // registered selection of default or stored code
    always_ff @(posedge mclk) begin
        if (rst) begin
            vendorId <= DEFAULT_VID;
            productId <= DEFAULT_PID;
        end else begin
            vendorId <= vidWritten ? storedVid : DEFAULT_VID;
            productId <= pidWritten ? storedPid : DEFAULT_PID;
        end
    end
endmodule
`default_nettype wire

// file: verification/upsi_top_assertions.sv
// handshake and pull-up checks at the top ports
`timescale 1ns/100ps
`default_nettype none
module upsi_top_assertions (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // bus channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic bus_supply_sense_in,
    input wire logic usb_data_positive_pullup
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // both write halves taken at one edge
    sequence wrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    write_answer_a: assert property (wrTaken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    read_answer_a: assert property (rdTaken |=> s_axi_rvalid)
        else $error("read data late");
    bresp_stands_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rdata_stands_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    bvalid_clears_a: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid)
        else $error("write response repeated");
    aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during response");
    ar_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during data");
    supply_pullup_a: assert property (bus_supply_sense_in[*2] |-> ##1 usb_data_positive_pullup)
        else $error("pull-up off with supply present");
endmodule
bind upsi_top upsi_top_assertions upsi_top_assertions_inst (.mclk, .rst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .bus_supply_sense_in, .usb_data_positive_pullup);
`default_nettype wire

// file: verification/upsi_host_model.sv
// far side: host supply level and its chosen product code
`timescale 1ns/100ps
`default_nettype none
module upsi_host_model (
    // clock and control
    input wire logic mclk,
    input wire logic present,
    // to the device
    output logic bus_supply_sense_in,
    output logic [15:0] newPid
);
    // supply level follows the host cable state
    always_ff @(posedge mclk) begin
        bus_supply_sense_in <= present;
    end
    assign newPid = 16'h3c3d;
endmodule
`default_nettype wire

// file: verification/usb_power_state_indicator_tb_top.sv
// register-level bench for the power state indicator
`timescale 1ns/100ps
`default_nettype none
module usb_power_state_indicator_tb_top;
    import upsi_pkg::*;
    localparam logic [15:0] TB_VID = 16'h2b2b; // arbitrary value
    localparam logic [15:0] TB_PID = 16'h4d4d; // arbitrary value
    logic mclk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp, rs;
    logic present = 1, sense, pin, pull, asrt, epin;
    logic [15:0] newPid;
    int miscompares = 0, total_checks = 0;
    upsi_top #(.DEFAULT_VID(TB_VID), .DEFAULT_PID(TB_PID)) upsi_top_inst (
        .mclk, .rst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .bus_supply_sense_in(sense),
        .power_permission_out(pin), .usb_data_positive_pullup(pull));
    upsi_host_model upsi_host_model_inst (.mclk, .present,
        .bus_supply_sense_in(sense), .newPid);
    initial begin
        forever #2 mclk = ~mclk;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    // bus write: both halves offered, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ap, wp;
        int n;
        ap = 1;
        wp = 1;
        @(posedge mclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf;
        awvalid <= 1; wvalid <= 1; bready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (!ap && !wp && bvalid) break;
            if (ap && awready) begin ap = 0; awvalid <= 0; end
            if (wp && wready) begin wp = 0; wvalid <= 0; end
        end
        rs = bresp;
        bready <= 0;
        if (n == 50) begin miscompares++; conclude(); end
    endtask
    // bus read, waits for the data beat
    task automatic rdr(input logic [7:0] a);
        int n;
        @(posedge mclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (!arvalid && rvalid) break;
            if (arvalid && arready) arvalid <= 0;
        end
        rd = rdata; rs = rresp;
        rready <= 0;
        if (n == 50) begin miscompares++; conclude(); end
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 0;
        rdr(UPSI_CTRL_OFS); check(rd, 32'h0000_3200);
        rdr(UPSI_STATUS_OFS); check(rd, 32'h6);
        rdr(UPSI_EPINFO_OFS); check(rd, UPSI_EPINFO);
        rdr(8'h20); check({rd[29:0], rs}, {30'h0, UPSI_RESP_SLVERR});
        wr(8'h20, 32'h1); check({30'h0, rs}, {30'h0, UPSI_RESP_SLVERR});
        $display("test reset and map done");
        // power classes, states and polarity
        for (int i = 0; i < 16; i++) begin
            wr(UPSI_OTP_OFS, {31'h0, i[3]});
            wr(UPSI_CTRL_OFS, {16'h0, i[2] ? 8'h33 : 8'h32, 6'h0, i[0], i[1]});
            asrt = i[1] | (i[2] & !i[0]);
            epin = i[3] ? asrt : !asrt;
            repeat (3) @(posedge mclk);
            check({31'h0, pin}, {31'h0, epin});
            rdr(UPSI_STATUS_OFS); check({30'h0, rd[1:0]}, {30'h0, epin, asrt});
        end
        $display("test power permission done");
        // supply sensing options
        for (int j = 0; j < 8; j++) begin
            present <= j[0];
            wr(UPSI_OTP_OFS, {29'h0, j[2], j[1], 1'b0});
            repeat (3) @(posedge mclk);
            check({31'h0, pull}, {31'h0, !(j[2] & j[1] & !j[0])});
        end
        present <= 1;
        $display("test supply sense done");
        rdr(UPSI_IDS_OFS); check(rd, {TB_PID, TB_VID});
        wr(UPSI_IDS_OFS, {newPid, 16'h2468});
        wr(UPSI_OTP_OFS, 32'h08);
        rdr(UPSI_IDS_OFS); check(rd, {TB_PID, 16'h2468});
        wr(UPSI_OTP_OFS, 32'h18);
        rdr(UPSI_IDS_OFS); check(rd, {newPid, 16'h2468});
        $display("test identity codes done");
        conclude();
    end
endmodule
`default_nettype wire
